// *** hdl/prog_pin_pkg.sv ***
package prog_pin_pkg;

  // -------------------------------------------------------------
  // Pin positions inside the synchronised pin vector
  // -------------------------------------------------------------
  localparam int PIN_COUNT      = 8;
  localparam int PIN_ENABLE_N   = 0;
  localparam int PIN_DATA_IN    = 1;
  localparam int PIN_MODE_CTRL  = 2;
  localparam int PIN_DATA_OUT   = 3;
  localparam int PIN_SHIFT_CLK  = 4;
  localparam int PIN_PRIMARY    = 5;
  localparam int PIN_RESET_CLK  = 6;
  localparam int PIN_GLOBAL_OE  = 7;

  // -------------------------------------------------------------
  // Reset values
  // -------------------------------------------------------------
  // Enable and reset/clock pins idle high: not programming, no reset asserted
  localparam logic [PIN_COUNT-1:0] PIN_RESET_VALUE = 8'h41;
  localparam int                   SHIFT_WIDTH     = 8;

  // -------------------------------------------------------------
  // Test-port state machine, Gray coded along idle-select-shift-update
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    PORT_IDLE   = 2'h0,
    PORT_SELECT = 2'h1,
    PORT_SHIFT  = 2'h3,
    PORT_UPDATE = 2'h2
  } port_state_type;

endpackage

// *** hdl/pin_sync.sv ***
`timescale 1ns/1ps

module pin_sync #(
  parameter int                 WIDTH      = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL  = '0
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_level;

  always_comb begin
    next_stage1 = resetn ? pin : RESET_VAL;
    next_level  = resetn ? stage1 : RESET_VAL;
  end

  always_ff @(posedge clk) begin
    stage1 <= next_stage1;
    level  <= next_level;
  end

endmodule

// *** hdl/prog_pin_function_select.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Programming mode holds while the enable pin is low; test pins live.
// - Data-in pin shifts programming data, else is logic input zero.
// - Mode-control pin steers the test-port state machine in programming.
// - Data-out pin shows shift bits in programming, else logic input one.
// - Shift-clock pin clocks the test port, else is a dedicated clock.
// - Reset/clock pin low resets the test-port state, shift register and data outputs, or acts as a clock.
// - Primary clock pin reaches a clock input of every logic block group.
// - Global output-enable pin gates the general-purpose output drivers.

module prog_pin_function_select #(
  parameter int GROUPS = 4,
  parameter int WIDTH  = prog_pin_pkg::SHIFT_WIDTH
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              prog_port_enable_n,
  input  wire logic              data_in_pin,
  input  wire logic              mode_ctrl_pin,
  input  wire logic              data_out_pin_in,
  output logic                   data_out_pin_out,
  output logic                   data_out_pin_oe,
  input  wire logic              shift_clk_pin,
  input  wire logic              primary_clock_pin,
  input  wire logic              reset_clock_pin,
  input  wire logic              reset_pin_is_clock,
  input  wire logic              global_oe_pin,
  output logic                   prog_mode,
  output logic                   logic_in0,
  output logic                   logic_in1,
  output logic [GROUPS-1:0]      primary_clock_en,
  output logic                   secondary_clock_en,
  output logic                   tertiary_clock_en,
  output logic                   global_reset_n,
  output logic                   io_output_enable,
  output logic [WIDTH-1:0]       prog_data,
  output logic                   prog_data_valid
);

  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  logic [prog_pin_pkg::PIN_COUNT-1:0] pins;
  logic [prog_pin_pkg::PIN_COUNT-1:0] lvl;

  assign pins = {global_oe_pin, reset_clock_pin, primary_clock_pin,
                 shift_clk_pin, data_out_pin_in, mode_ctrl_pin,
                 data_in_pin, prog_port_enable_n};

  pin_sync #(
    .WIDTH     (prog_pin_pkg::PIN_COUNT),
    .RESET_VAL (prog_pin_pkg::PIN_RESET_VALUE)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    (pins),
    .level  (lvl)
  );

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  prog_pin_pkg::port_state_type state;
  prog_pin_pkg::port_state_type next_state;
  logic              tck_q, y0_q, y1_q;
  logic              next_tck_q, next_y0_q, next_y1_q;
  logic [WIDTH-1:0]  shreg, next_shreg;
  logic [WIDTH-1:0]  next_prog_data;
  logic              next_prog_data_valid;
  logic              next_data_out_pin_out, next_data_out_pin_oe;
  logic              next_prog_mode, next_logic_in0, next_logic_in1;
  logic [GROUPS-1:0] next_primary_clock_en;
  logic              next_secondary_clock_en, next_tertiary_clock_en;
  logic              next_global_reset_n, next_io_output_enable;
  logic              progl, tck_rise, pin_reset;

  always_comb begin
    progl     = ~lvl[prog_pin_pkg::PIN_ENABLE_N];
    tck_rise  = lvl[prog_pin_pkg::PIN_SHIFT_CLK] & ~tck_q;
    pin_reset = ~reset_pin_is_clock
              & ~lvl[prog_pin_pkg::PIN_RESET_CLK];

    next_tck_q = lvl[prog_pin_pkg::PIN_SHIFT_CLK];
    next_y0_q  = lvl[prog_pin_pkg::PIN_PRIMARY];
    next_y1_q  = lvl[prog_pin_pkg::PIN_RESET_CLK];
    next_state = state;
    next_shreg = shreg;
    next_prog_data       = prog_data;
    next_prog_data_valid = 1'b0;

    // Test port advances only on shift-clock edges while programming
    if (progl && tck_rise) begin
      case (state)
        prog_pin_pkg::PORT_IDLE: begin
          if (lvl[prog_pin_pkg::PIN_MODE_CTRL]) begin
            next_state = prog_pin_pkg::PORT_SELECT;
          end
        end
        prog_pin_pkg::PORT_SELECT: begin
          next_state = lvl[prog_pin_pkg::PIN_MODE_CTRL]
                     ? prog_pin_pkg::PORT_IDLE : prog_pin_pkg::PORT_SHIFT;
        end
        prog_pin_pkg::PORT_SHIFT: begin
          next_shreg = {lvl[prog_pin_pkg::PIN_DATA_IN],
                        shreg[WIDTH-1:1]};
          if (lvl[prog_pin_pkg::PIN_MODE_CTRL]) begin
            next_state = prog_pin_pkg::PORT_UPDATE;
          end
        end
        prog_pin_pkg::PORT_UPDATE: begin
          next_prog_data       = shreg;
          next_prog_data_valid = 1'b1;
          next_state = lvl[prog_pin_pkg::PIN_MODE_CTRL]
                     ? prog_pin_pkg::PORT_SELECT : prog_pin_pkg::PORT_IDLE;
        end
        default: next_state = prog_pin_pkg::PORT_IDLE;
      endcase
    end
    if (!progl) begin
      next_state = prog_pin_pkg::PORT_IDLE;
    end

    // Roles follow the current enable level, registered at the next clock edge
    next_prog_mode        = progl;
    next_data_out_pin_oe  = progl;
    next_data_out_pin_out = progl & shreg[0];
    next_logic_in0 = ~progl & lvl[prog_pin_pkg::PIN_DATA_IN];
    next_logic_in1 = ~progl & lvl[prog_pin_pkg::PIN_DATA_OUT];
    next_tertiary_clock_en = ~progl & tck_rise;
    next_primary_clock_en  = {GROUPS{lvl[prog_pin_pkg::PIN_PRIMARY]
                                     & ~y0_q}};
    next_secondary_clock_en = reset_pin_is_clock
                            & lvl[prog_pin_pkg::PIN_RESET_CLK] & ~y1_q;
    next_global_reset_n   = ~pin_reset;
    next_io_output_enable = lvl[prog_pin_pkg::PIN_GLOBAL_OE];

    if (pin_reset) begin
      next_state           = prog_pin_pkg::PORT_IDLE;
      next_shreg           = '0;
      next_prog_data       = '0;
      next_prog_data_valid = 1'b0;
      next_data_out_pin_out = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state              <= prog_pin_pkg::PORT_IDLE;
      tck_q              <= 1'b0;
      y0_q               <= 1'b0;
      y1_q               <= 1'b1;
      shreg              <= '0;
      prog_data          <= '0;
      prog_data_valid    <= 1'b0;
      data_out_pin_out   <= 1'b0;
      data_out_pin_oe    <= 1'b0;
      prog_mode          <= 1'b0;
      logic_in0          <= 1'b0;
      logic_in1          <= 1'b0;
      primary_clock_en   <= '0;
      secondary_clock_en <= 1'b0;
      tertiary_clock_en  <= 1'b0;
      global_reset_n     <= 1'b1;
      io_output_enable   <= 1'b0;
    end else begin
      state              <= next_state;
      tck_q              <= next_tck_q;
      y0_q               <= next_y0_q;
      y1_q               <= next_y1_q;
      shreg              <= next_shreg;
      prog_data          <= next_prog_data;
      prog_data_valid    <= next_prog_data_valid;
      data_out_pin_out   <= next_data_out_pin_out;
      data_out_pin_oe    <= next_data_out_pin_oe;
      prog_mode          <= next_prog_mode;
      logic_in0          <= next_logic_in0;
      logic_in1          <= next_logic_in1;
      primary_clock_en   <= next_primary_clock_en;
      secondary_clock_en <= next_secondary_clock_en;
      tertiary_clock_en  <= next_tertiary_clock_en;
      global_reset_n     <= next_global_reset_n;
      io_output_enable   <= next_io_output_enable;
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_MODE_FOLLOWS: assert property (
    ##1 prog_mode == !$past(lvl[prog_pin_pkg::PIN_ENABLE_N]))
    else $error("prog_mode does not follow enable pin");
  AST_IN0_ROLE: assert property (
    prog_mode |-> !logic_in0)
    else $error("logic_in0 active in programming mode");
  AST_SHIFT_STEER: assert property (
    (progl && tck_rise && state == prog_pin_pkg::PORT_IDLE
     && !lvl[prog_pin_pkg::PIN_MODE_CTRL] && !pin_reset)
    |=> state == prog_pin_pkg::PORT_IDLE)
    else $error("test port left idle with mode control low");
  AST_TDO_DRIVE: assert property (
    data_out_pin_oe == prog_mode)
    else $error("data out enable differs from mode");
  AST_IN1_ROLE: assert property (
    prog_mode |-> !logic_in1)
    else $error("logic_in1 active in programming mode");
  AST_PORT_IDLE: assert property (
    !prog_mode |-> state == prog_pin_pkg::PORT_IDLE)
    else $error("test port active outside programming");
  AST_TDO_OFF_IDLE: assert property (
    !prog_mode |-> !data_out_pin_out)
    else $error("data out driven outside programming");
  AST_TCK_ROLE: assert property (
    prog_mode |-> !tertiary_clock_en)
    else $error("dedicated clock pulse while programming");
  AST_RESET_PIN: assert property (
    pin_reset |=> !global_reset_n && state == prog_pin_pkg::PORT_IDLE
                  && prog_data == '0)
    else $error("reset pin did not clear registers");
  AST_GROUP_CLOCK: assert property (
    primary_clock_en == '0 || primary_clock_en == '1)
    else $error("groups see different primary clock");
  AST_GLOBAL_OE: assert property (
    ##1 io_output_enable == $past(lvl[prog_pin_pkg::PIN_GLOBAL_OE]))
    else $error("output enable does not follow pin");
  AST_NO_WAIT: assert property (
    $fell(lvl[prog_pin_pkg::PIN_ENABLE_N]) |=> prog_mode && data_out_pin_oe)
    else $error("role change waited");

  COV_ENTER_PROG: cover property ($rose(prog_mode));
  COV_UPDATE:     cover property (prog_data_valid);
  COV_PIN_RESET:  cover property ($fell(global_reset_n));
  COV_SEC_CLK:    cover property (secondary_clock_en);

endmodule

// *** verif/prog_ctrl_model.sv ***
`timescale 1ns/1ps
module prog_ctrl_model (
  input  wire logic clk,
  input  wire logic data_out_pin_out,
  input  wire logic data_out_pin_oe,
  output logic      prog_port_enable_n,
  output logic      data_in_pin,
  output logic      mode_ctrl_pin,
  output logic      shift_clk_pin
);
  initial begin
    prog_port_enable_n = 1'h1;
    data_in_pin = 1'h0;
    mode_ctrl_pin = 1'h0;
    shift_clk_pin = 1'h0;
  end
  // Released mode pin floats: show the inverse of its last value
  task automatic set_port(input logic en_n);
    prog_port_enable_n = en_n;
    if (en_n) begin
      mode_ctrl_pin = ~mode_ctrl_pin;
    end
  endtask
  // One 200 ns shift-clock period, entered and left at a falling clk edge
  // Mode pin is only driven while programming
  task automatic tick(input logic m, input logic d, output logic q);
    if (!prog_port_enable_n) begin
      mode_ctrl_pin = m;
    end
    data_in_pin = d;
    repeat (3) @(negedge clk);
    q = data_out_pin_oe ? data_out_pin_out : ~data_out_pin_out;
    @(negedge clk);
    shift_clk_pin = 1'h1;
    repeat (4) @(negedge clk);
    shift_clk_pin = 1'h0;
  endtask
  // Idle edge, select, shift eight bits LSB first, update; old word read back
  task automatic frame(input logic [7:0] w, output logic [7:0] rb);
    logic q;
    tick(1'h0, 1'h0, q);
    tick(1'h1, 1'h0, q);
    tick(1'h0, 1'h0, q);
    for (int i = 0; i < 8; i++) begin
      tick(i == 7, w[i], q);
      rb[i] = q;
    end
    tick(1'h0, 1'h0, q);
    repeat (8) @(negedge clk);
  endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic       clk, resetn, pri_pin, rst_pin, rst_is_clk, goe_pin, ext_in1;
  logic       en_n, d_in, mode, sclk, d_out, d_oe, d_pin, prog_mode;
  logic       in0, in1, sec_en, ter_en, grst_n, io_oe, valid;
  logic [3:0] pri_en;
  logic [7:0] prog_data, word;
  int         bad_count = 0, checks_done = 0;
  int         n_pri = 0, n_sec = 0, n_ter = 0, n_val = 0;

  assign d_pin = d_oe ? d_out : ext_in1;

  prog_pin_function_select prog_pin_function_select_i (
    .clk(clk), .resetn(resetn), .prog_port_enable_n(en_n),
    .data_in_pin(d_in), .mode_ctrl_pin(mode), .data_out_pin_in(d_pin),
    .data_out_pin_out(d_out), .data_out_pin_oe(d_oe),
    .shift_clk_pin(sclk), .primary_clock_pin(pri_pin),
    .reset_clock_pin(rst_pin), .reset_pin_is_clock(rst_is_clk),
    .global_oe_pin(goe_pin), .prog_mode(prog_mode), .logic_in0(in0),
    .logic_in1(in1), .primary_clock_en(pri_en),
    .secondary_clock_en(sec_en), .tertiary_clock_en(ter_en),
    .global_reset_n(grst_n), .io_output_enable(io_oe),
    .prog_data(prog_data), .prog_data_valid(valid));

  prog_ctrl_model prog_ctrl_model_i (
    .clk(clk), .data_out_pin_out(d_out), .data_out_pin_oe(d_oe),
    .prog_port_enable_n(en_n), .data_in_pin(d_in),
    .mode_ctrl_pin(mode), .shift_clk_pin(sclk));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (pri_en == 4'hf) n_pri++;
    if (sec_en) n_sec++;
    if (ter_en) n_ter++;
    if (valid) n_val++;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_clk(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic final_report;
    $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic t_inputs;
    for (int i = 0; i < 4; i++) begin
      prog_ctrl_model_i.data_in_pin = i[0];
      ext_in1 = i[1];
      goe_pin = i[0] ^ i[1];
      wait_clk(5);
      check("logic_in0", i[0], in0);
      check("logic_in1", i[1], in1);
      check("io_output_enable", i[0] ^ i[1], io_oe);
    end
  endtask

  task automatic t_clocks;
    int p, s, t;
    logic q;
    p = n_pri;
    s = n_sec;
    t = n_ter;
    rst_is_clk = 1'h1;
    repeat (3) begin
      pri_pin = 1'h1;
      rst_pin = 1'h0;
      wait_clk(4);
      pri_pin = 1'h0;
      rst_pin = 1'h1;
      wait_clk(4);
    end
    prog_ctrl_model_i.tick(1'h1, 1'h0, q);
    prog_ctrl_model_i.tick(1'h0, 1'h0, q);
    wait_clk(6);
    check("primary pulses", 3, n_pri - p);
    check("secondary pulses", 3, n_sec - s);
    check("tertiary pulses", 2, n_ter - t);
    check("global_reset_n", 1'h1, grst_n);
    rst_is_clk = 1'h0;
  endtask

  task automatic t_prog;
    int v, t;
    prog_ctrl_model_i.data_in_pin = 1'h1;
    prog_ctrl_model_i.set_port(1'h0);
    wait_clk(5);
    check("prog_mode", 1'h1, prog_mode);
    check("data_out_pin_oe", 1'h1, d_oe);
    check("logic_in0", 1'h0, in0);
    v = n_val;
    t = n_ter;
    prog_ctrl_model_i.frame(8'ha5, word);
    check("prog_data", 8'ha5, prog_data);
    check("logic_in1", 1'h0, in1);
    prog_ctrl_model_i.frame(8'h3c, word);
    check("readback", 8'ha5, word);
    check("prog_data", 8'h3c, prog_data);
    check("valid pulses", 2, n_val - v);
    check("tertiary pulses", 0, n_ter - t);
    prog_ctrl_model_i.set_port(1'h1);
    wait_clk(5);
    check("prog_mode", 1'h0, prog_mode);
    check("data_out_pin_oe", 1'h0, d_oe);
  endtask

  task automatic t_reset_pin;
    rst_pin = 1'h0;
    wait_clk(5);
    check("global_reset_n", 1'h0, grst_n);
    check("prog_data", 8'h00, prog_data);
    rst_pin = 1'h1;
    wait_clk(5);
    check("global_reset_n", 1'h1, grst_n);
  endtask

  initial begin
    resetn = 1'h0;
    pri_pin = 1'h0;
    rst_pin = 1'h1;
    rst_is_clk = 1'h0;
    goe_pin = 1'h0;
    ext_in1 = 1'h0;
    wait_clk(6);
    resetn = 1'h1;
    wait_clk(2);
    check("prog_mode", 1'h0, prog_mode);
    check("global_reset_n", 1'h1, grst_n);
    check("primary pulses", 0, n_pri);
    t_inputs;
    t_clocks;
    t_prog;
    t_reset_pin;
    final_report;
  end

  initial begin
    #50000;
    bad_count++;
    $display("Error watchdog expected done seen hang");
    final_report;
  end
endmodule
